// ### bench/mds_host_clear.sv
// host model that runs the fault clear sequence on the clear input
// assumes the bench sets both run inputs as each scenario needs
`timescale 1ns/100ps
`default_nettype none
module mds_host_clear (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // request from the bench
  input wire logic go,
  input wire logic [7:0] len,
  // clear input of the device, end marker
  output logic clear_out,
  output logic done
);
  logic [7:0] cnt;
  initial clear_out = 1'b0;
  initial done = 1'b0;
  // hold clear for len cycles then drop it; the drop is what clears
  always @(posedge sys_clk or posedge rst) begin
    done <= 1'b0;
    if (rst) clear_out <= 1'b0;
    else if (go) begin
      clear_out <= 1'b1;
      cnt <= len;
    end else if (clear_out) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h01) begin
        clear_out <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule : mds_host_clear
`default_nettype wire

// ### bench/mds_status_out_assertions.sv
// checker for the status output block, bound to its top ports
// assumes the 10 MHz sys_clk and a speed pulse of 2000 cycles
`timescale 1ns/100ps
`default_nettype none
module mds_status_out_assertions #(
  parameter int unsigned CLEAR_HOLD_CYCLES = 20
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // watched inputs
  input wire logic rev_tick_in,
  input wire logic fault_trip_in,
  input wire logic fault_clear_in,
  input wire logic run_cw_in,
  input wire logic run_ccw_in,
  input wire logic overload_fault_in,
  input wire logic warning_in,
  input wire logic shaft_fwd_in,
  input wire logic torque_at_limit_in,
  input wire logic internal_busy_in,
  input wire logic main_power_in,
  input wire logic speed_at_set_in,
  input wire logic [3:0] speed_select_in,
  // watched outputs
  input wire logic speed_pulse_out,
  input wire logic fault_out_primary,
  input wire logic motion_out,
  input wire logic overload_out,
  input wire logic caution_out,
  input wire logic rotation_fwd_out,
  input wire logic torque_limited_out,
  input wire logic internal_busy_out,
  input wire logic main_power_on_out,
  input wire logic speed_reached_out,
  input wire logic echo_run_cw,
  input wire logic [3:0] echo_speed_sel
);
  localparam logic [11:0] PW = 12'h7d0;
  logic [11:0] pcnt_reg;
  int unsigned hold_reg;
  logic trip_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // cycles since last tick, saturating at the pulse width
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) pcnt_reg <= PW;
    else if (rev_tick_in) pcnt_reg <= 12'h000;
    else if (pcnt_reg < PW) pcnt_reg <= pcnt_reg + 12'h001;
  end
  // qualified clear length; a run input restarts the count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) hold_reg <= 0;
    else if (fault_clear_in && !run_cw_in && !run_ccw_in) hold_reg <= hold_reg + (hold_reg < CLEAR_HOLD_CYCLES);
    else hold_reg <= 0;
  end
  // startup rise of the fault output is not a clear, so wait for a trip
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) trip_reg <= 1'b0;
    else if (fault_trip_in) trip_reg <= 1'b1;
  end
  property p_pulse_start; rev_tick_in |=> speed_pulse_out; endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("speed pulse missing after tick");
  property p_pulse_width; speed_pulse_out == (pcnt_reg < PW); endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("speed pulse width wrong");
  property p_trip; fault_trip_in |-> ##[1:2] !fault_out_primary; endproperty
  a_trip: assert property (p_trip) else $error("fault output stayed on after trip");
  property p_rise_cause;
    $rose(fault_out_primary) && trip_reg |-> $past(!fault_clear_in && !run_cw_in && !run_ccw_in, 2);
  endproperty
  a_rise_cause: assert property (p_rise_cause) else $error("fault cleared without falling clear");
  property p_clear_hold; $rose(fault_out_primary) && trip_reg |-> $past(hold_reg, 2) >= CLEAR_HOLD_CYCLES; endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("fault cleared after short hold");
  property p_motion; run_cw_in || run_ccw_in |=> motion_out; endproperty
  a_motion: assert property (p_motion) else $error("motion output off while running");
  property p_echo; echo_speed_sel == $past(speed_select_in) && echo_run_cw == $past(run_cw_in); endproperty
  a_echo: assert property (p_echo) else $error("echo output differs from input");
  property p_overload; overload_fault_in |=> !overload_out; endproperty
  a_overload: assert property (p_overload) else $error("overload output on during fault");
  property p_caution; caution_out == $past(warning_in); endproperty
  a_caution: assert property (p_caution) else $error("caution output wrong");
  property p_levels;
    {rotation_fwd_out, torque_limited_out, internal_busy_out, main_power_on_out, speed_reached_out}
      == $past({shaft_fwd_in, torque_at_limit_in, internal_busy_in, main_power_in, speed_at_set_in});
  endproperty
  a_levels: assert property (p_levels) else $error("level status output wrong");
endmodule : mds_status_out_assertions
bind mds_status_out mds_status_out_assertions #(.CLEAR_HOLD_CYCLES(CLEAR_HOLD_CYCLES)) u_chk (.*);
`default_nettype wire

// ### bench/mds_status_out_bench.sv
// self-checking bench for the status output block
// assumes the design package and constants header are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "mds_consts.svh"
module mds_status_out_bench;
  localparam int unsigned HOLD = 20;
  logic sys_clk = 1'b0, rst = 1'b1, psel, penable, pwrite, pready, pslverr, e, ctl, clr_go, clr_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, v, c;
  logic run_cw_in, run_ccw_in, stop_mode_in, brake_release_in, operator_lock_in, torque_limit_en_in;
  logic fault_clear_in, rev_tick_in, shaft_fwd_in, motor_stopped_in, fault_trip_in, overload_fault_in;
  logic overload_level_in, warning_in, torque_at_limit_in, speed_at_set_in, internal_busy_in, main_power_in;
  logic [3:0] speed_select_in, echo_speed_sel;
  logic [6:0] direct_in;
  logic [1:0] direct_out;
  logic [15:0] net_stat_out;
  logic [7:0] clr_len;
  logic speed_pulse_out, fault_out_primary, fault_lamp, motor_stop_instant, brake_engage, motion_out;
  logic speed_reached_out, overload_out, caution_out, torque_limited_out, internal_busy_out, main_power_on_out;
  logic rotation_fwd_out, echo_run_cw, echo_run_ccw, echo_stop_mode, echo_brake_release, echo_operator_lock;
  logic echo_torque_limit_en;
  int failures = 0, checks = 0, cyc = 0, n, w, i;
  mds_status_out #(.CLEAR_HOLD_CYCLES(HOLD)) dut (.*);
  mds_host_clear host (.sys_clk, .rst, .go(clr_go), .len(clr_len), .clear_out(fault_clear_in), .done(clr_done));
  // clock and hang guard
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      summarize();
    end
  end
  // ****
  // tasks
  // ****
  task chk(input string name, input logic [31:0] seen, input logic [31:0] expv);
    checks++;
    if (seen !== expv) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, expv, seen);
    end
  endtask : chk
  // one apb transfer; the request stands until pready is seen
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task clear_seq(input logic [7:0] len);
    int k;
    @(posedge sys_clk);
    {clr_go, clr_len} <= {1'b1, len};
    @(posedge sys_clk);
    clr_go <= 1'b0;
    for (k = 0; k < 300 && clr_done !== 1'b1; k++) @(posedge sys_clk);
  endtask : clear_seq
  task summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // ****
  // main sequence
  // ****
  initial begin
    {psel, penable, pwrite, paddr, pwdata, run_cw_in, run_ccw_in, stop_mode_in, brake_release_in} = '0;
    {operator_lock_in, torque_limit_en_in, rev_tick_in, shaft_fwd_in, motor_stopped_in, fault_trip_in} = '0;
    {overload_fault_in, overload_level_in, warning_in, torque_at_limit_in, speed_at_set_in} = '0;
    {internal_busy_in, main_power_in, speed_select_in, direct_in, clr_go, clr_len} = '0;
    v = $urandom(32'h18f7cafb);
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("fault_out_primary", fault_out_primary, 1);
    chk("overload_out", overload_out, 1);
    apb(0, `MDS_ADDR_CTRL, 0);
    chk("ctrl reset", r, `MDS_CTRL_RST);
    apb(1, `MDS_ADDR_CTRL, 32'h7);
    apb(0, `MDS_ADDR_CTRL, 0);
    chk("ctrl", r, 32'h7);
    v = $urandom;
    apb(1, `MDS_ADDR_NETCMD, v);
    apb(0, `MDS_ADDR_NETCMD, 0);
    chk("netcmd", r[15:0], v[15:0]);
    chk("direct_out", direct_out, v[1:0]);
    for (i = 0; i < 4; i++) begin
      apb(1, `MDS_ADDR_CONTACT, {25'h0, i[1], 6'h00});
      direct_in <= {i[0], v[5:0]};
      repeat (3) @(posedge sys_clk);
      chk("net_stat_out", net_stat_out, {i[0] ^ i[1], 15'h0000});
    end
    apb(1, `MDS_ADDR_STATUS, 32'hffff);
    chk("status write refused", e, 1);
    apb(0, 12'h100, 0);
    chk("unmapped refused", e, 1);
    $display("test registers done");
    n = 0;
    repeat (30) begin
      @(posedge sys_clk);
      rev_tick_in <= 1'b1;
      @(posedge sys_clk);
      rev_tick_in <= 1'b0;
      w = 0;
      repeat (2002) begin
        @(posedge sys_clk);
        w += speed_pulse_out;
      end
      n += (w == 2000);
    end
    chk("full pulses", n, 30);
    apb(0, `MDS_ADDR_SPEED, 0);
    chk("speed tick count", r, 30);
    $display("test speed pulse done");
    // standard, brake type, brake after coast
    for (i = 0; i < 3; i++) begin
      c = (i == 2) ? 3 : i;
      apb(1, `MDS_ADDR_CTRL, c);
      motor_stopped_in <= 1'b0;
      @(posedge sys_clk);
      fault_trip_in <= 1'b1;
      @(posedge sys_clk);
      fault_trip_in <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk("fault_out_primary", fault_out_primary, 0);
      chk("motor_stop_instant", motor_stop_instant, c == 1);
      chk("brake_engage", brake_engage, c == 1);
      chk("fault_lamp", fault_lamp, 1);
      motor_stopped_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk("brake_engage stopped", brake_engage, c[0]);
      run_cw_in <= 1'b1;
      clear_seq(HOLD + 5);
      repeat (4) @(posedge sys_clk);
      chk("clear while running", fault_out_primary, 0);
      run_cw_in <= 1'b0;
      clear_seq(HOLD - 1);
      repeat (4) @(posedge sys_clk);
      chk("short clear", fault_out_primary, 0);
      clear_seq(HOLD + 2);
      chk("clear before fall", fault_out_primary, 0);
      repeat (4) @(posedge sys_clk);
      chk("clear after fall", fault_out_primary, 1);
      chk("fault_lamp off", fault_lamp, 0);
    end
    $display("test fault done");
    for (i = 0; i < 16; i++) begin
      if (i % 8 == 0) apb(1, `MDS_ADDR_CTRL, (i == 0) ? 32'h4 : 32'h0);
      ctl = (i < 8);
      v = $urandom;
      {run_cw_in, run_ccw_in, stop_mode_in, brake_release_in, operator_lock_in, speed_select_in, torque_limit_en_in,
        shaft_fwd_in, overload_fault_in, overload_level_in, warning_in, torque_at_limit_in, speed_at_set_in,
        internal_busy_in, main_power_in} <= v[17:0];
      repeat (2) @(posedge sys_clk);
      chk("levels", {motion_out, echo_run_cw, echo_run_ccw, echo_stop_mode, echo_brake_release, echo_operator_lock,
        echo_speed_sel, echo_torque_limit_en, rotation_fwd_out, overload_out, caution_out, torque_limited_out,
        speed_reached_out, internal_busy_out, main_power_on_out},
        {v[17] | v[16], v[17:8], v[7], !(v[6] | (ctl & v[5])), v[4:0]});
    end
    $display("test levels done");
    summarize();
  end
endmodule : mds_status_out_bench
`default_nettype wire

// ### rtl/mds_consts.svh
// constants for the motor driver status output block
// assumes a 10 MHz system clock
`ifndef MDS_CONSTS_SVH
`define MDS_CONSTS_SVH

`define MDS_CLK_HZ 10000000
`define MDS_PULSE_WIDTH_US 200
`define MDS_PULSE_CYCLES ((`MDS_PULSE_WIDTH_US * (`MDS_CLK_HZ / 1000000)))
`define MDS_CLEAR_HOLD_MS 10
`define MDS_CLEAR_HOLD_CYCLES ((`MDS_CLEAR_HOLD_MS * (`MDS_CLK_HZ / 1000)))
`define MDS_PULSES_PER_REV 30
`define MDS_CNT_W 20
`define MDS_BLINK_W 23

// register byte offsets
`define MDS_ADDR_CTRL 12'h000
`define MDS_ADDR_NETCMD 12'h004
`define MDS_ADDR_CONTACT 12'h008
`define MDS_ADDR_STATUS 12'h00c
`define MDS_ADDR_NETSTAT 12'h010
`define MDS_ADDR_SPEED 12'h014

// control register fields
`define MDS_CTRL_BRAKE_TYPE 0
`define MDS_CTRL_BRAKE_AFTER_COAST 1
`define MDS_CTRL_OVL_WARN_EN 2

`define MDS_CTRL_RST 32'h0000_0000
`define MDS_CONTACT_RST 32'h0000_0000

`endif

// ### rtl/mds_pkg.sv
// types for the motor driver status output block
// assumes nothing of its surroundings
package mds_pkg;
  typedef enum logic [1:0] {
    MDS_CLR_IDLE,
    MDS_CLR_HOLD,
    MDS_CLR_ARMED
  } mds_clr_e;
endpackage : mds_pkg

// ### rtl/mds_status_out.sv
// status and monitor outputs of a brushless motor driver, with an apb register file
// assumes synchronous inputs from the motor control core and a 10 MHz sys_clk
`timescale 1ns/100ps
`default_nettype none
`include "mds_consts.svh"

module mds_status_out #(
  parameter int unsigned CLEAR_HOLD_CYCLES = `MDS_CLEAR_HOLD_CYCLES,
  parameter int unsigned N_DIR_IN = 7,
  parameter int unsigned N_DIR_OUT = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command inputs, on means conducting
  input wire logic run_cw_in,
  input wire logic run_ccw_in,
  input wire logic stop_mode_in,
  input wire logic brake_release_in,
  input wire logic operator_lock_in,
  input wire logic [3:0] speed_select_in,
  input wire logic torque_limit_en_in,
  input wire logic fault_clear_in,
  // motor core status
  input wire logic rev_tick_in,
  input wire logic shaft_fwd_in,
  input wire logic motor_stopped_in,
  input wire logic fault_trip_in,
  input wire logic overload_fault_in,
  input wire logic overload_level_in,
  input wire logic warning_in,
  input wire logic torque_at_limit_in,
  input wire logic speed_at_set_in,
  input wire logic internal_busy_in,
  input wire logic main_power_in,
  // direct terminals
  input wire logic [N_DIR_IN-1:0] direct_in,
  // status outputs
  output logic speed_pulse_out,
  output logic fault_out_primary,
  output logic fault_lamp,
  output logic motor_stop_instant,
  output logic brake_engage,
  output logic motion_out,
  output logic speed_reached_out,
  output logic overload_out,
  output logic caution_out,
  output logic torque_limited_out,
  output logic internal_busy_out,
  output logic main_power_on_out,
  output logic rotation_fwd_out,
  // echo outputs
  output logic echo_run_cw,
  output logic echo_run_ccw,
  output logic echo_stop_mode,
  output logic echo_brake_release,
  output logic echo_operator_lock,
  output logic [3:0] echo_speed_sel,
  output logic echo_torque_limit_en,
  // general purpose routing
  output logic [N_DIR_OUT-1:0] direct_out,
  output logic [15:0] net_stat_out
);

  // ***************************************************
  // register file
  // ***************************************************
  logic [31:0] ctrl_reg;
  logic [15:0] net_cmd_reg;
  logic [N_DIR_IN-1:0] contact_reg;
  logic [15:0] net_stat_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // address decode
  wire access = psel && penable && !pready_reg;
  wire sel_ctrl = (paddr == `MDS_ADDR_CTRL);
  wire sel_netcmd = (paddr == `MDS_ADDR_NETCMD);
  wire sel_contact = (paddr == `MDS_ADDR_CONTACT);
  wire sel_status = (paddr == `MDS_ADDR_STATUS);
  wire sel_netstat = (paddr == `MDS_ADDR_NETSTAT);
  wire sel_speed = (paddr == `MDS_ADDR_SPEED);
  wire mapped = sel_ctrl || sel_netcmd || sel_contact || sel_status || sel_netstat || sel_speed;
  wire read_only = sel_status || sel_netstat || sel_speed;
  // a write lands only at the edge that completes the transfer, with pready high
  wire commit = psel && penable && pready_reg;
  wire wr_ok = commit && pwrite && mapped && !read_only;

  wire brake_type = ctrl_reg[`MDS_CTRL_BRAKE_TYPE];
  wire brake_after_coast = ctrl_reg[`MDS_CTRL_BRAKE_AFTER_COAST];
  wire ovl_warn_en = ctrl_reg[`MDS_CTRL_OVL_WARN_EN];

  // status word gathers the fault and level status outputs, not speed_pulse_out
  wire [31:0] status_word = {20'h0_0000,
    rotation_fwd_out,
    main_power_on_out,
    internal_busy_out,
    torque_limited_out,
    caution_out,
    overload_out,
    speed_reached_out,
    motion_out,
    brake_engage,
    motor_stop_instant,
    fault_lamp,
    fault_out_primary};
  logic [15:0] rev_count_reg;

  // read mux; unmapped addresses read as zero and raise pslverr
  wire [31:0] rd_mux = sel_ctrl ? ctrl_reg :
    sel_netcmd ? {16'h0000, net_cmd_reg} :
    sel_contact ? {{(32 - N_DIR_IN){1'b0}}, contact_reg} :
    sel_status ? status_word :
    sel_netstat ? {16'h0000, net_stat_reg} :
    sel_speed ? {16'h0000, rev_count_reg} : 32'h0000_0000;

  // one wait state: answer the cycle after penable rises
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= access;
      pslverr_reg <= access && (!mapped || (pwrite && read_only));
      prdata_reg <= (access && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // software writable registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `MDS_CTRL_RST;
      net_cmd_reg <= 16'h0000;
      contact_reg <= '0;
    end else if (wr_ok) begin
      if (sel_ctrl) ctrl_reg <= pwdata;
      else if (sel_netcmd) net_cmd_reg <= pwdata[15:0];
      else if (sel_contact) contact_reg <= pwdata[N_DIR_IN-1:0];
    end
  end

  // ***************************************************
  // speed pulse
  // ***************************************************
  logic [`MDS_CNT_W-1:0] pulse_cnt_reg;
  logic speed_pulse_reg;
  // a tick arriving mid-pulse restarts the width; ticks closer than 0.2 ms merge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pulse_cnt_reg <= '0;
      speed_pulse_reg <= 1'b0;
      rev_count_reg <= 16'h0000;
    end else if (rev_tick_in) begin
      pulse_cnt_reg <= `MDS_CNT_W'(`MDS_PULSE_CYCLES - 1);
      speed_pulse_reg <= 1'b1;
      rev_count_reg <= rev_count_reg + 16'h0001;
    end else if (pulse_cnt_reg != '0) begin
      pulse_cnt_reg <= pulse_cnt_reg - `MDS_CNT_W'(1);
    end else begin
      speed_pulse_reg <= 1'b0;
    end
  end

  // ***************************************************
  // fault latch and clear sequence
  // ***************************************************
  // hold_cnt_reg counts held edges, the entry edge being the first of them
  mds_pkg::mds_clr_e clr_state_reg;
  logic [`MDS_CNT_W-1:0] hold_cnt_reg;
  logic fault_reg;
  wire run_any = run_cw_in || run_ccw_in;
  wire hold_done = (hold_cnt_reg >= `MDS_CNT_W'(CLEAR_HOLD_CYCLES - 1));
  wire clear_fire = (clr_state_reg == mds_pkg::MDS_CLR_ARMED) && !fault_clear_in && !run_any;

  // clear input must stay on 10 ms with both run inputs off
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clr_state_reg <= mds_pkg::MDS_CLR_IDLE;
      hold_cnt_reg <= '0;
    end else begin
      case (clr_state_reg)
        mds_pkg::MDS_CLR_IDLE: begin
          if (fault_clear_in && !run_any) begin
            clr_state_reg <= mds_pkg::MDS_CLR_HOLD;
            hold_cnt_reg <= `MDS_CNT_W'(1);
          end else begin
            hold_cnt_reg <= '0;
          end
        end
        mds_pkg::MDS_CLR_HOLD: begin
          if (run_any || !fault_clear_in) clr_state_reg <= mds_pkg::MDS_CLR_IDLE;
          else if (hold_done) clr_state_reg <= mds_pkg::MDS_CLR_ARMED;
          else hold_cnt_reg <= hold_cnt_reg + `MDS_CNT_W'(1);
        end
        mds_pkg::MDS_CLR_ARMED: begin
          if (run_any || !fault_clear_in) clr_state_reg <= mds_pkg::MDS_CLR_IDLE;
        end
        default: clr_state_reg <= mds_pkg::MDS_CLR_IDLE;
      endcase
    end
  end

  // trip wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) fault_reg <= 1'b0;
    else if (fault_trip_in) fault_reg <= 1'b1;
    else if (clear_fire) fault_reg <= 1'b0;
  end

  // lamp blinks at about 1.2 Hz while a fault stands
  logic [`MDS_BLINK_W-1:0] blink_cnt_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) blink_cnt_reg <= '0;
    else blink_cnt_reg <= fault_reg ? blink_cnt_reg + `MDS_BLINK_W'(1) : '0;
  end

  // ***************************************************
  // status outputs, all registered
  // ***************************************************
  // a trip reaches the outputs at the edge that latches it; only direct_in[6] feeds the network
  wire fault_now = fault_reg || fault_trip_in;
  wire [N_DIR_IN-1:0] dir_active = direct_in ^ contact_reg;
  wire [15:0] net_stat_next = {dir_active[N_DIR_IN-1], {(16 - 1){1'b0}}};

  // fault outputs; the brake choice follows the control register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fault_out_primary <= 1'b0;
      fault_lamp <= 1'b0;
      motor_stop_instant <= 1'b0;
      brake_engage <= 1'b0;
    end else begin
      fault_out_primary <= !fault_now;
      fault_lamp <= fault_now && !blink_cnt_reg[`MDS_BLINK_W-1];
      motor_stop_instant <= fault_now && brake_type && !brake_after_coast;
      brake_engage <= fault_now && brake_type && (!brake_after_coast || motor_stopped_in);
    end
  end

  // level status outputs, one cycle behind their causes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      motion_out <= 1'b0;
      speed_reached_out <= 1'b0;
      overload_out <= 1'b0;
      caution_out <= 1'b0;
      torque_limited_out <= 1'b0;
      internal_busy_out <= 1'b0;
      main_power_on_out <= 1'b0;
      rotation_fwd_out <= 1'b0;
    end else begin
      motion_out <= run_any;
      speed_reached_out <= speed_at_set_in;
      overload_out <= !((ovl_warn_en && overload_level_in) || overload_fault_in);
      caution_out <= warning_in;
      torque_limited_out <= torque_at_limit_in;
      internal_busy_out <= internal_busy_in;
      main_power_on_out <= main_power_in;
      rotation_fwd_out <= shaft_fwd_in;
    end
  end

  // general purpose routing; bits not routed stay off
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      net_stat_reg <= 16'h0000;
      direct_out <= '0;
    end else begin
      net_stat_reg <= net_stat_next;
      direct_out <= net_cmd_reg[N_DIR_OUT-1:0];
    end
  end

  // ***************************************************
  // echo outputs
  // ***************************************************
  // echo outputs mirror the command inputs except fault_clear_in
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      echo_run_cw <= 1'b0;
      echo_run_ccw <= 1'b0;
      echo_stop_mode <= 1'b0;
      echo_brake_release <= 1'b0;
      echo_operator_lock <= 1'b0;
      echo_speed_sel <= 4'h0;
      echo_torque_limit_en <= 1'b0;
    end else begin
      echo_run_cw <= run_cw_in;
      echo_run_ccw <= run_ccw_in;
      echo_stop_mode <= stop_mode_in;
      echo_brake_release <= brake_release_in;
      echo_operator_lock <= operator_lock_in;
      echo_speed_sel <= speed_select_in;
      echo_torque_limit_en <= torque_limit_en_in;
    end
  end

  // ***************************************************
  // port drive
  // ***************************************************
  // port drive, every level is ON = conducting
  assign speed_pulse_out = speed_pulse_reg;
  assign net_stat_out = net_stat_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule : mds_status_out
`default_nettype wire
